// [shared/cmbtp_pkg.sv]
// package for the can message buffer with local transmit prioritisation
package cmbtp_pkg;
    // ==========================================================
    // register map (byte offsets inside the window)
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_IDENT_HIGH = 8'h00;
    localparam logic [7:0] OFF_IDENT_LOW = 8'h01;
    localparam logic [7:0] OFF_PAYLOAD0 = 8'h04;
    localparam logic [7:0] OFF_PAYLOAD7 = 8'h0b;
    localparam logic [7:0] OFF_LENGTH = 8'h0c;
    localparam logic [7:0] OFF_LOCAL_LOCAL_PRIORITY = 8'h0d;
    localparam logic [7:0] OFF_TX_FLAG = 8'h10;
    localparam logic [7:0] OFF_TX_SELECT = 8'h11;
    localparam logic [7:0] OFF_STATUS = 8'h12;
    localparam logic [7:0] OFF_RX_WINDOW = 8'h20;
    // ==========================================================
    // field layout
    localparam int RTR_BIT = 4;
    localparam int IDE_BIT = 3;
    localparam int ID_LOW_MSB = 7;
    localparam int ID_LOW_LSB = 5;
    localparam int DLC_MSB = 3;
    localparam logic [3:0] DLC_MAX = 4'h8;
    localparam logic [3:0] BYTE_CNT_MAX = 4'h8;
    localparam logic [7:0] TX_EMPTY_RESET = 8'h07;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int STD_ID_W = 11;
    // ==========================================================
    // frame handed to the bit engine
    typedef struct packed {
        logic [10:0] frameIdentifier;
        logic        remoteReq;
        logic        extFormat;
        logic [3:0]  lengthCode;
        logic [3:0]  byteCount;
        logic [63:0] payloadBits;
    } cmbtp_frame_t;
    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cmbtp_bus_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_WAIT = 2'b10
    } cmbtp_state_t;
endpackage

// [design/cmbtp_msg_buffer.sv]
// message buffers with local transmit prioritisation
`timescale 1ns/10ps
module cmbtp_msg_buffer #(
    parameter int NUM_TX = 3
) (
    input  wire logic                     clk_sys,
    input  wire logic                     reset_n,
    input  wire logic [7:0]               busAddr,
    input  wire logic [7:0]               busWdata,
    input  wire logic                     busWr,
    input  wire logic                     busRd,
    output logic [7:0]                    busRdata,
    // bit engine side
    input  wire logic                     sofReady,
    input  wire logic                     txDone,
    input  wire logic                     rxValid,
    input  wire cmbtp_pkg::cmbtp_frame_t  rxFrame,
    output cmbtp_pkg::cmbtp_frame_t       txFrame,
    output logic                          txStart,
    output logic [1:0]                    txIndex
);
    // ==========================================================
    // storage
    logic [7:0] identHigh_r [NUM_TX+1];
    logic [7:0] identLow_r  [NUM_TX+1];
    logic [7:0] payload_r   [NUM_TX+1][8];
    logic [7:0] lengthCode_r[NUM_TX+1];
    logic [7:0] localPrio_r [NUM_TX];
    logic [NUM_TX-1:0] txEmpty_r;
    logic [NUM_TX-1:0] txSelect_r;
    logic [1:0] activeIdx_r;
    cmbtp_pkg::cmbtp_state_t state_r;
    logic [1:0] selIdx;
    logic       selValid;

    // buffer index chosen by the select register, lowest set bit
    function automatic logic [1:0] firstSet(input logic [NUM_TX-1:0] v);
        firstSet = 2'h0;
        for (int i = NUM_TX - 1; i >= 0; i--) begin
            if (v[i]) begin
                firstSet = 2'(i);
            end
        end
    endfunction

    // byte count from a length code
    function automatic logic [3:0] byteCount(input logic [3:0] dlc, input logic rtr);
        if (rtr) begin
            byteCount = 4'h0;
        end else if (dlc > cmbtp_pkg::DLC_MAX) begin
            byteCount = cmbtp_pkg::BYTE_CNT_MAX;
        end else begin
            byteCount = dlc;
        end
    endfunction

    // ==========================================================
    // payload window decode, shared by write and read paths
    function automatic logic isPayload(input logic [7:0] o);
        isPayload = (o >= cmbtp_pkg::OFF_PAYLOAD0) && (o <= cmbtp_pkg::OFF_PAYLOAD7);
    endfunction

    // payload byte slot from an offset
    function automatic logic [2:0] payloadSlot(input logic [7:0] o);
        logic [7:0] rel;
        rel = o - cmbtp_pkg::OFF_PAYLOAD0;
        payloadSlot = rel[2:0];
    endfunction

    logic [1:0] hostIdx;
    logic       hostOk;
    logic       rxWin;
    logic [1:0] bufIdx;
    logic [7:0] off;
    assign hostIdx = firstSet(txSelect_r);
    assign hostOk = (txSelect_r != '0) && txEmpty_r[hostIdx];
    assign rxWin = busAddr >= cmbtp_pkg::OFF_RX_WINDOW;
    assign bufIdx = rxWin ? 2'(NUM_TX) : hostIdx;
    assign off = rxWin ? busAddr - cmbtp_pkg::OFF_RX_WINDOW : busAddr;

    // ==========================================================
    // local prioritisation
    always_comb begin
        selValid = 1'b0;
        selIdx = 2'h0;
        for (int i = 0; i < NUM_TX; i++) begin
            if (!txEmpty_r[i]) begin
                // strict less keeps the lower index on ties
                if (!selValid || localPrio_r[i] < localPrio_r[selIdx]) begin
                    selValid = 1'b1;
                    selIdx = 2'(i);
                end
            end
        end
    end

    // ==========================================================
    // host writes and receive capture
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            for (int b = 0; b <= NUM_TX; b++) begin
                identHigh_r[b] <= cmbtp_pkg::ZERO_BYTE;
                identLow_r[b] <= cmbtp_pkg::ZERO_BYTE;
                lengthCode_r[b] <= cmbtp_pkg::ZERO_BYTE;
                for (int k = 0; k < 8; k++) begin
                    payload_r[b][k] <= cmbtp_pkg::ZERO_BYTE;
                end
            end
            for (int b = 0; b < NUM_TX; b++) begin
                localPrio_r[b] <= cmbtp_pkg::ZERO_BYTE;
            end
            txSelect_r <= '0;
        end else begin
            if (busWr) begin
                if (busAddr == cmbtp_pkg::OFF_TX_SELECT) begin
                    txSelect_r <= busWdata[NUM_TX-1:0];
                end else if (hostOk && !rxWin) begin
                    if (off == cmbtp_pkg::OFF_IDENT_HIGH) begin
                        identHigh_r[bufIdx] <= busWdata;
                    end else if (off == cmbtp_pkg::OFF_IDENT_LOW) begin
                        identLow_r[bufIdx] <= busWdata;
                    end else if (isPayload(off)) begin
                        payload_r[bufIdx][payloadSlot(off)] <= busWdata;
                    end else if (off == cmbtp_pkg::OFF_LENGTH) begin
                        lengthCode_r[bufIdx] <= {4'h0, busWdata[cmbtp_pkg::DLC_MSB:0]};
                    end else if (off == cmbtp_pkg::OFF_LOCAL_LOCAL_PRIORITY) begin
                        localPrio_r[bufIdx] <= busWdata;
                    end
                end
            end
            // receive buffer keeps the frame as received, payload bytes past the byte count stored as zero
            if (rxValid) begin
                identHigh_r[NUM_TX] <= rxFrame.frameIdentifier[10:3];
                identLow_r[NUM_TX] <= {rxFrame.frameIdentifier[2:0], rxFrame.remoteReq,
                                       rxFrame.extFormat, 3'h0};
                lengthCode_r[NUM_TX] <= {4'h0, rxFrame.lengthCode};
                for (int k = 0; k < 8; k++) begin
                    payload_r[NUM_TX][k] <= (4'(k) < byteCount(rxFrame.lengthCode,
                        rxFrame.remoteReq)) ? rxFrame.payloadBits[8*k +: 8]
                        : cmbtp_pkg::ZERO_BYTE;
                end
            end
        end
    end

    // ==========================================================
    // empty flags: host clears by writing one, completion sets
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            txEmpty_r <= cmbtp_pkg::TX_EMPTY_RESET[NUM_TX-1:0];
        end else begin
            for (int i = 0; i < NUM_TX; i++) begin
                if (txDone && state_r == cmbtp_pkg::ST_WAIT && activeIdx_r == 2'(i)) begin
                    txEmpty_r[i] <= 1'b1;
                end else if (busWr && busAddr == cmbtp_pkg::OFF_TX_FLAG && busWdata[i]) begin
                    txEmpty_r[i] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // transmit sequencing
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r <= cmbtp_pkg::ST_IDLE;
            activeIdx_r <= 2'h0;
            txStart <= 1'b0;
            txIndex <= 2'h0;
            txFrame <= '0;
        end else begin
            txStart <= 1'b0;
            case (state_r)
                cmbtp_pkg::ST_IDLE: begin
                    if (sofReady && selValid) begin
                        state_r <= cmbtp_pkg::ST_WAIT;
                        activeIdx_r <= selIdx;
                        txIndex <= selIdx;
                        txStart <= 1'b1;
                        // id msb first, numeric order gives bus priority
                        txFrame.frameIdentifier <= {identHigh_r[selIdx],
                            identLow_r[selIdx][cmbtp_pkg::ID_LOW_MSB:cmbtp_pkg::ID_LOW_LSB]};
                        txFrame.remoteReq <= identLow_r[selIdx][cmbtp_pkg::RTR_BIT];
                        txFrame.extFormat <= identLow_r[selIdx][cmbtp_pkg::IDE_BIT];
                        txFrame.lengthCode <= lengthCode_r[selIdx][3:0];
                        txFrame.byteCount <= byteCount(lengthCode_r[selIdx][3:0],
                            identLow_r[selIdx][cmbtp_pkg::RTR_BIT]);
                        for (int k = 0; k < 8; k++) begin
                            txFrame.payloadBits[8*k +: 8] <= payload_r[selIdx][k];
                        end
                    end
                end
                cmbtp_pkg::ST_WAIT: begin
                    if (txDone) begin
                        state_r <= cmbtp_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= cmbtp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // read path, data one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            busRdata <= cmbtp_pkg::ZERO_BYTE;
        end else begin
            busRdata <= cmbtp_pkg::ZERO_BYTE;
            if (busRd) begin
                if (busAddr == cmbtp_pkg::OFF_TX_FLAG) begin
                    busRdata <= 8'(txEmpty_r);
                end else if (busAddr == cmbtp_pkg::OFF_TX_SELECT) begin
                    busRdata <= 8'(txSelect_r);
                end else if (busAddr == cmbtp_pkg::OFF_STATUS) begin
                    busRdata <= {4'h0, selValid, state_r == cmbtp_pkg::ST_WAIT, activeIdx_r};
                end else if (rxWin || hostOk) begin
                    if (off == cmbtp_pkg::OFF_IDENT_HIGH) begin
                        busRdata <= identHigh_r[bufIdx];
                    end else if (off == cmbtp_pkg::OFF_IDENT_LOW) begin
                        busRdata <= identLow_r[bufIdx];
                    end else if (isPayload(off)) begin
                        busRdata <= payload_r[bufIdx][payloadSlot(off)];
                    end else if (off == cmbtp_pkg::OFF_LENGTH) begin
                        busRdata <= lengthCode_r[bufIdx];
                    end else if (off == cmbtp_pkg::OFF_LOCAL_LOCAL_PRIORITY && !rxWin) begin
                        busRdata <= localPrio_r[hostIdx];
                    end
                end
            end
        end
    end
endmodule // cmbtp_msg_buffer

// [bench/cmbtp_msg_buffer_assertions.sv]
// checker on the message buffer ports
`timescale 1ns/10ps
module cmbtp_msg_buffer_assertions #(
    parameter int NUM_TX = 3
) (
    input wire logic                    clk_sys,
    input wire logic                    reset_n,
    input wire logic                    busRd,
    input wire logic [7:0]              busRdata,
    input wire logic                    sofReady,
    input wire logic                    txDone,
    input wire cmbtp_pkg::cmbtp_frame_t txFrame,
    input wire logic                    txStart,
    input wire logic [1:0]              txIndex
);
    logic busyR;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // ==========================================================
    // transmit busy tracker
    always_ff @(posedge clk_sys) begin
        if (!reset_n || txDone)
            busyR <= 1'b0;
        else if (txStart)
            busyR <= 1'b1;
    end
    // ==========================================================
    // properties
    chk_start_pulse: assert property (txStart |=> !txStart)
        else $error("start pulse too long");
    chk_start_cause: assert property (txStart |-> $past(sofReady) && !$past(busyR))
        else $error("start without free bus");
    chk_busy_quiet: assert property (busyR |-> !txStart)
        else $error("start while busy");
    chk_remote_empty: assert property (
        txStart && txFrame.remoteReq |-> txFrame.byteCount == 4'h0)
        else $error("remote frame carries data");
    chk_count_code: assert property (
        txStart && !txFrame.remoteReq && txFrame.lengthCode <= 4'h8
        |-> txFrame.byteCount == txFrame.lengthCode)
        else $error("byte count differs from code");
    chk_count_cap: assert property (
        txStart && !txFrame.remoteReq && txFrame.lengthCode > 4'h8
        |-> txFrame.byteCount == 4'h8)
        else $error("long code not capped");
    chk_index_range: assert property (txStart |-> txIndex < NUM_TX)
        else $error("index out of range");
    chk_frame_hold: assert property (!txStart |-> $stable(txFrame) && $stable(txIndex))
        else $error("frame moved without start");
    chk_read_idle: assert property (!$past(busRd) |-> busRdata == 8'h00)
        else $error("read data without read");
    cov_remote: cover property (txStart && txFrame.remoteReq);
    cov_last_buf: cover property (txStart && txIndex == 2'h2);
    cov_capped: cover property (txStart && txFrame.byteCount == 4'h8);
endmodule // cmbtp_msg_buffer_assertions
bind cmbtp_msg_buffer cmbtp_msg_buffer_assertions #(.NUM_TX(NUM_TX)) i_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .busRd(busRd), .busRdata(busRdata),
    .sofReady(sofReady), .txDone(txDone), .txFrame(txFrame), .txStart(txStart),
    .txIndex(txIndex));

// [bench/cmbtp_engine_model.sv]
// far side bit engine model
`timescale 1ns/10ps
module cmbtp_engine_model (
    input wire logic                clk_sys,
    input wire logic                reset_n,
    input wire logic                goEn,
    input wire logic [3:0]          holdCycles,
    input wire logic                txStart,
    output logic                    sofReady,
    output logic                    txDone,
    output logic                    rxValid,
    output cmbtp_pkg::cmbtp_frame_t rxFrame
);
    logic [3:0] waitR;
    logic       busyR;
    initial rxValid = 1'b0;
    initial rxFrame = '1;
    // bus offered only while idle
    assign sofReady = goEn && !busyR && !txDone;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            busyR <= 1'b0;
            txDone <= 1'b0;
            waitR <= 4'h0;
        end else begin
            txDone <= busyR && waitR == 4'h0;
            busyR <= txStart || (busyR && waitR != 4'h0);
            waitR <= txStart ? holdCycles : waitR - 4'h1;
        end
    end
    task sendRx(input cmbtp_pkg::cmbtp_frame_t f);
        rxFrame <= f;
        rxValid <= 1'b1;
        @(posedge clk_sys);
        rxFrame <= ~f;
        rxValid <= 1'b0;
    endtask
endmodule // cmbtp_engine_model

// [bench/cmbtp_msg_buffer_test.sv]
// self-checking bench for the message buffers
`timescale 1ns/10ps
module cmbtp_msg_buffer_test;
    logic                    clk_sys = 1'b0;
    logic                    reset_n, busWr, busRd, sofReady, txDone, rxValid, txStart, goEn;
    logic                    rdPend;
    logic [7:0]              busAddr, busWdata, busRdata, rm;
    logic [3:0]              holdCycles;
    logic [1:0]              txIndex;
    logic [31:0]             lfsrR = 32'h8cca8806;
    logic [63:0]             expM[3];
    cmbtp_pkg::cmbtp_frame_t rxFrame, txFrame, rxF, gotF, expF[3], frQ[$];
    logic [63:0]             pmQ[$];
    logic [7:0]              rdQ[$], rmQ[$];
    logic [1:0]              ixQ[$];
    int                      ord[3] = '{1, 2, 0};
    int                      miscompares = 0, check_count = 0, cycles = 0;
    always #5 clk_sys = ~clk_sys;
    cmbtp_msg_buffer #(.NUM_TX(3)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
        .busRdata(busRdata), .sofReady(sofReady), .txDone(txDone), .rxValid(rxValid),
        .rxFrame(rxFrame), .txFrame(txFrame), .txStart(txStart), .txIndex(txIndex));
    cmbtp_engine_model i_eng (.clk_sys(clk_sys), .reset_n(reset_n), .goEn(goEn),
        .holdCycles(holdCycles), .txStart(txStart), .sofReady(sofReady),
        .txDone(txDone), .rxValid(rxValid), .rxFrame(rxFrame));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task test_done;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
        busWr <= w;
        busRd <= !w;
        busAddr <= a;
        busWdata <= d;
        if (!w) begin
            rdQ.push_back(d);
            rmQ.push_back(m);
        end
        @(posedge clk_sys);
    endtask
    task idle;
        busWr <= 1'b0;
        busRd <= 1'b0;
        @(posedge clk_sys);
    endtask
    // ==========================================================
    // load one transmit buffer and note its frame
    task fill(input int k);
        logic [7:0] lo, pr;
        cmbtp_pkg::cmbtp_frame_t f;
        lfsrR = lfsr(lfsrR);
        f = '0;
        f.frameIdentifier = lfsrR[10:0];
        f.remoteReq = (k == 1);
        f.extFormat = (k == 2);
        f.lengthCode = (k == 0) ? 4'hf : (k == 1) ? 4'h3 : 4'h5;
        f.byteCount = f.remoteReq ? 4'h0 : (f.lengthCode > 4'h8) ? 4'h8 : f.lengthCode;
        lo = {f.frameIdentifier[2:0], f.remoteReq, f.extFormat, 3'h0};
        pr = (k == 0) ? 8'h05 : 8'h02;
        bus(1'b1, 8'h11, 8'(8'h01 << k), 8'h00);
        bus(1'b1, 8'h00, f.frameIdentifier[10:3], 8'h00);
        bus(1'b1, 8'h01, lo, 8'h00);
        for (int b = 0; b < 8; b++) begin
            lfsrR = lfsr(lfsrR);
            f.payloadBits[8*b +: 8] = lfsrR[7:0];
            expM[k][8*b +: 8] = (b < f.byteCount) ? 8'hff : 8'h00;
            bus(1'b1, 8'(8'h04 + b), lfsrR[7:0], 8'h00);
        end
        bus(1'b1, 8'h0c, {4'h0, f.lengthCode}, 8'h00);
        bus(1'b1, 8'h0d, pr, 8'h00);
        bus(1'b0, 8'h01, lo, 8'hf8);
        bus(1'b0, 8'h0b, f.payloadBits[63:56], 8'hff);
        bus(1'b0, 8'h0c, {4'h0, f.lengthCode}, 8'h0f);
        bus(1'b0, 8'h0d, pr, 8'hff);
        f.payloadBits &= expM[k];
        expF[k] = f;
    endtask
    // ==========================================================
    // watchers and timeout
    always @(posedge clk_sys) begin
        rdPend <= busRd && reset_n;
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares++;
            test_done;
        end
    end
    always @(negedge clk_sys) begin
        if (rdPend === 1'b1 && rdQ.size() > 0) begin
            rm = rmQ.pop_front();
            chk((busRdata & rm) === (rdQ.pop_front() & rm), "read data");
        end
        if (txStart === 1'b1 && frQ.size() > 0) begin
            gotF = txFrame;
            gotF.payloadBits &= pmQ.pop_front();
            chk((gotF === frQ.pop_front()) & (txIndex === ixQ.pop_front()), "frame");
        end else if (txStart === 1'b1)
            chk(1'b0, "extra frame");
    end
    // ==========================================================
    // main sequence
    initial begin
        reset_n = 1'b0;
        busWr = 1'b0;
        busRd = 1'b0;
        busAddr = 8'h00;
        busWdata = 8'h00;
        goEn = 1'b0;
        holdCycles = 4'h0;
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        bus(1'b0, 8'h10, 8'h07, 8'hff);
        bus(1'b0, 8'h0e, 8'h00, 8'hff);
        for (int k = 0; k < 3; k++)
            fill(k);
        bus(1'b1, 8'h10, 8'h07, 8'h00);
        bus(1'b1, 8'h11, 8'h02, 8'h00);
        bus(1'b0, 8'h0d, 8'h00, 8'hff);
        idle;
        foreach (ord[i]) begin
            frQ.push_back(expF[ord[i]]);
            pmQ.push_back(expM[ord[i]]);
            ixQ.push_back(2'(ord[i]));
        end
        holdCycles <= lfsrR[3:0];
        goEn <= 1'b1;
        for (int w = 0; w < 200 && frQ.size() > 0; w++)
            @(posedge clk_sys);
        repeat (20) @(posedge clk_sys);
        goEn <= 1'b0;
        chk(frQ.size() == 0, "frames missing");
        bus(1'b0, 8'h10, 8'h07, 8'hff);
        bus(1'b0, 8'h12, 8'h00, 8'hff);
        idle;
        rxF = '0;
        rxF.frameIdentifier = 11'h5a3;
        rxF.remoteReq = 1'b1;
        rxF.extFormat = 1'b1;
        i_eng.sendRx(rxF);
        bus(1'b0, 8'h20, 8'hb4, 8'hff);
        bus(1'b0, 8'h21, 8'h78, 8'hf8);
        idle;
        repeat (3) @(posedge clk_sys);
        test_done;
    end
endmodule // cmbtp_msg_buffer_test
